// File: src/e1_rx_frame_sync_control.v
// e1 receive framer control, status and interrupt logic with apb slave
//
// Contract
// - each link owns its register copy, second link 0x100 above first
// - unframed bypass routes line stream around the frame processor
// - excess crc restarts search only with auto reframe also on
// - auto reframe off keeps frame locked; only manual request reframes
// - auto reframe on starts a new search on basic frame loss
// - manual reframe acts on a written 0 to 1 change only
// - loss after three fas pattern errors, or three non_align_word if selected
// - cas multiframe search runs after basic sync only when enabled
// - crc multiframe search runs after basic sync only when enabled
// - error criteria pick fas bit, fas word, plus non_align_word errors
// - cas loss on two pattern errors or zero ts16 per setting
// - interworking stops crc search unless keep searching is set
// - interwork flag shows interworking mode, reset 0
// - cas multiframe loss flag, reset 1
// - crc multiframe loss flag, reset 1
// - offline frame loss flag, reset 0
// - basic frame loss flag, reset 1
// - five enables gate change indications onto interrupt, reset 0
// - eight enables gate event indications onto interrupt, reset 0
// - change indication sets on any transition of its status flag
// - indications clear on written 1, written 0 leaves them
// - 915 crc-4 errors in one second while in sync is excessive
`default_nettype none
`include "e1_rx_frame_sync_defs.vh"
module e1_rx_frame_sync_control #(
    parameter LINKS = 2,
    parameter WINDOW_CYCLES = `FS_WINDOW_S * `FS_CLOCK_HZ
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_clk_en,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire [LINKS-1:0] i_line_bit,
    input wire [LINKS-1:0] i_proc_bit,
    input wire [LINKS-1:0] i_frame_found,
    input wire [LINKS-1:0] i_fas_chk,
    input wire [LINKS-1:0] i_fas_bit_err,
    input wire [LINKS-1:0] i_fas_pat_err,
    input wire [LINKS-1:0] i_non_align_word_chk,
    input wire [LINKS-1:0] i_non_align_word_err,
    input wire [LINKS-1:0] i_align_moved,
    input wire [LINKS-1:0] i_offline_oos,
    input wire [LINKS-1:0] i_cas_mf_found,
    input wire [LINKS-1:0] i_cas_mf_chk,
    input wire [LINKS-1:0] i_cas_pat_err,
    input wire [LINKS-1:0] i_ts16_zero,
    input wire [LINKS-1:0] i_cas_mf_start,
    input wire [LINKS-1:0] i_crc_mf_found,
    input wire [LINKS-1:0] i_crc_mf_start,
    input wire [LINKS-1:0] i_crc_submf_start,
    input wire [LINKS-1:0] i_crc_pat_err,
    input wire [LINKS-1:0] i_crc4_err,
    input wire [LINKS-1:0] i_interwork,
    output reg [LINKS-1:0] o_rx_bit,
    output reg [LINKS-1:0] o_frame_search,
    output reg [LINKS-1:0] o_cas_search,
    output reg [LINKS-1:0] o_crc_search,
    output reg [LINKS-1:0] o_unframed,
    output reg o_int_b
);
    // word index within a link, or all ones when unmapped
    function [2:0] reg_sel;
        input [11:0] addr;
        reg [7:0] low;
        begin
            low = addr[9:2];
            if (addr[1:0] != 2'h0 || addr[11] != 1'b0 ||
                low < `FS_IDX_MODE0 || low > `FS_IDX_EVENT_IND) begin
                reg_sel = 3'h7;
            end else begin
                reg_sel = low[2:0] - 3'h5;
            end
        end
    endfunction

    // which link copy an address falls
    function link_of;
        input [11:0] addr;
        begin
            link_of = addr[10];
        end
    endfunction

    wire [2:0] sel;
    wire link;
    wire hit;
    wire access;
    wire commit;
    wire [LINKS-1:0] wr_l;
    wire [LINKS-1:0] irq_l;
    wire [LINKS-1:0] fsrch_l;
    wire [LINKS-1:0] csrch_l;
    wire [LINKS-1:0] rsrch_l;
    wire [LINKS-1:0] unf_l;
    wire [8*LINKS-1:0] rdata_all;
    wire [7:0] wdata;

    assign sel = reg_sel(i_paddr);
    assign link = link_of(i_paddr);
    assign hit = (sel != 3'h7) && (link < LINKS);
    assign access = i_psel & i_penable;
    assign commit = access & o_pready;
    assign wdata = i_pwdata[7:0];

    // apb slave: answer on the second access cycle
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0;
            o_pslverr <= 1'b0;
        end else if (i_clk_en) begin
            if (access && !o_pready) begin
                o_pready <= 1'b1;
                o_pslverr <= ~hit;
                if (hit && !i_pwrite) begin
                    o_prdata <= {24'h0, rdata_all[link*8 +: 8]};
                end else begin
                    o_prdata <= 32'h0;
                end
            end else begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LINKS; g = g + 1) begin : lnk
            reg [3:0] mode0_r;
            reg [7:0] mode1_r;
            reg [4:0] stat_r;
            reg [4:0] sen_r;
            reg [7:0] een_r;
            reg [5:0] sind_r;
            reg [7:0] eind_r;
            reg [1:0] fas_cnt_r;
            reg [1:0] non_align_word_cnt_r;
            reg [1:0] cpat_cnt_r;
            reg zero_seen_r;
            reg [4:0] stat_nxt;
            reg [7:0] rd;
            wire wr;
            wire unf;
            wire auto;
            wire bsync;
            wire csync;
            wire rsync;
            wire iw_block;
            wire manual_fire;
            wire excess;
            wire fas_loss;
            wire non_align_word_loss;
            wire lose_b;
            wire restart;
            wire found_b;
            wire cas_lose;
            wire ferr;
            wire [5:0] sset;
            wire [7:0] eset;

            // register copy selected by this link's address window
            assign wr = commit & i_pwrite & hit & (link == g);
            assign wr_l[g] = wr;
            assign unf = mode0_r[`FS_M0_UNFRAMED];
            assign auto = mode0_r[`FS_M0_AUTO];
            assign bsync = ~stat_r[`FS_ST_BASIC];
            assign csync = ~stat_r[`FS_ST_CAS];
            assign rsync = ~stat_r[`FS_ST_CRC];
            assign iw_block = stat_r[`FS_ST_INTERWORK] &
                ~mode1_r[`FS_M1_KEEP_SRCH];
            assign manual_fire = wr && sel == 3'h0 &&
                wdata[`FS_M0_MANUAL] && !mode0_r[`FS_M0_MANUAL];
            assign fas_loss = i_fas_chk[g] & i_fas_pat_err[g] &
                (fas_cnt_r >= `FS_FAS_LOSS_CNT - 2'h1);
            assign non_align_word_loss = mode1_r[`FS_M1_LOSS_CRIT] &
                i_non_align_word_chk[g] & i_non_align_word_err[g] &
                (non_align_word_cnt_r >= `FS_FAS_LOSS_CNT - 2'h1);
            // locked in frame unless automatic reframing is on
            assign lose_b = ~unf & bsync & auto & (fas_loss | non_align_word_loss);
            assign restart = manual_fire |
                (excess & mode0_r[`FS_M0_REF_CRC] & auto);
            assign found_b = ~unf & i_frame_found[g];
            assign cas_lose = ~unf & csync & i_cas_mf_chk[g] &
                ((i_cas_pat_err[g] &
                  cpat_cnt_r == `FS_CAS_LOSS_CNT - 2'h1) |
                 (mode1_r[`FS_M1_ZERO_CHK] & i_ts16_zero[g] &
                  (~mode1_r[`FS_M1_TS16_SPAN] | zero_seen_r)));
            assign ferr = bsync & ((i_fas_chk[g] &
                (mode1_r[`FS_M1_WORD_ERR] ? i_fas_pat_err[g] :
                 i_fas_bit_err[g])) |
                (mode1_r[`FS_M1_CNT_NON_ALIGN_WORD] & i_non_align_word_chk[g] &
                 i_non_align_word_err[g]));

            e1_excess_crc_monitor #(
                .WINDOW_CYCLES(WINDOW_CYCLES),
                .THRESH(`FS_EXCESS_THRESH)
            ) u_excess (
                .i_clock(i_clock),
                .i_rst_b(i_rst_b),
                .i_clk_en(i_clk_en),
                .i_in_sync(rsync & ~unf),
                .i_crc_err(i_crc4_err[g]),
                .o_excess(excess)
            );

            // next sync status
            always @* begin
                stat_nxt = stat_r;
                if (restart | lose_b) begin
                    stat_nxt[`FS_ST_BASIC] = 1'b1;
                end else if (found_b) begin
                    stat_nxt[`FS_ST_BASIC] = 1'b0;
                end
                if (!mode1_r[`FS_M1_CAS_EN] || stat_nxt[`FS_ST_BASIC] ||
                    cas_lose) begin
                    stat_nxt[`FS_ST_CAS] = 1'b1;
                end else if (i_cas_mf_found[g] && !unf) begin
                    stat_nxt[`FS_ST_CAS] = 1'b0;
                end
                if (!mode1_r[`FS_M1_CRC_EN] || stat_nxt[`FS_ST_BASIC]) begin
                    stat_nxt[`FS_ST_CRC] = 1'b1;
                end else if (i_crc_mf_found[g] && !unf && !iw_block) begin
                    stat_nxt[`FS_ST_CRC] = 1'b0;
                end
                stat_nxt[`FS_ST_OFFLINE] = i_offline_oos[g];
                stat_nxt[`FS_ST_INTERWORK] = i_interwork[g] & ~unf;
            end

            // change flags on any status transition, plus excess crc
            assign sset = {excess, stat_nxt ^ stat_r};
            assign eset = {8{~unf}} & {
                i_cas_mf_start[g] & csync,
                i_crc_submf_start[g] & rsync,
                i_cas_mf_chk[g] & i_cas_pat_err[g] & csync,
                i_crc_mf_start[g] & rsync,
                i_crc_pat_err[g] & rsync,
                i_crc4_err[g] & rsync,
                ferr,
                i_align_moved[g]};

            always @(posedge i_clock or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    mode0_r <= `FS_MODE0_RST;
                    mode1_r <= `FS_MODE1_RST;
                    stat_r <= `FS_STATUS_RST;
                    sen_r <= 5'h00;
                    een_r <= 8'h00;
                    sind_r <= 6'h00;
                    eind_r <= 8'h00;
                    fas_cnt_r <= 2'h0;
                    non_align_word_cnt_r <= 2'h0;
                    cpat_cnt_r <= 2'h0;
                    zero_seen_r <= 1'b0;
                end else if (i_clk_en) begin
                    stat_r <= stat_nxt;
                    if (wr && sel == 3'h0) begin
                        mode0_r <= wdata[3:0];
                    end
                    if (wr && sel == 3'h1) begin
                        mode1_r <= wdata;
                    end
                    if (wr && sel == 3'h3) begin
                        sen_r <= wdata[4:0];
                    end
                    if (wr && sel == 3'h4) begin
                        een_r <= wdata;
                    end
                    // write one clears, a new event wins
                    sind_r <= (sind_r & ~((wr && sel == 3'h5) ?
                        wdata[5:0] : 6'h00)) | sset;
                    eind_r <= (eind_r & ~((wr && sel == 3'h6) ?
                        wdata : 8'h00)) | eset;
                    // consecutive fas and non_align_word error counts
                    if (!bsync || restart) begin
                        fas_cnt_r <= 2'h0;
                        non_align_word_cnt_r <= 2'h0;
                    end else begin
                        if (i_fas_chk[g]) begin
                            fas_cnt_r <= i_fas_pat_err[g] ?
                                (fas_cnt_r == `FS_FAS_LOSS_CNT ?
                                 fas_cnt_r : fas_cnt_r + 2'h1) : 2'h0;
                        end
                        if (i_non_align_word_chk[g]) begin
                            non_align_word_cnt_r <= i_non_align_word_err[g] ?
                                (non_align_word_cnt_r == `FS_FAS_LOSS_CNT ?
                                 non_align_word_cnt_r : non_align_word_cnt_r + 2'h1) : 2'h0;
                        end
                    end
                    // consecutive cas pattern count and previous zero ts16 flag
                    if (!csync || cas_lose) begin
                        cpat_cnt_r <= 2'h0;
                        zero_seen_r <= 1'b0;
                    end else if (i_cas_mf_chk[g]) begin
                        cpat_cnt_r <= i_cas_pat_err[g] ?
                            cpat_cnt_r + 2'h1 : 2'h0;
                        zero_seen_r <= i_ts16_zero[g];
                    end
                end
            end

            // read mux
            always @* begin
                case (sel)
                    3'h0: rd = {4'h0, mode0_r};
                    3'h1: rd = mode1_r;
                    3'h2: rd = {3'h0, stat_r};
                    3'h3: rd = {3'h0, sen_r};
                    3'h4: rd = een_r;
                    3'h5: rd = {2'h0, sind_r};
                    3'h6: rd = eind_r;
                    default: rd = 8'h00;
                endcase
            end
            assign rdata_all[g*8 +: 8] = rd;

            // enabled indications raise the interrupt
            assign irq_l[g] = (|(sind_r[4:0] & sen_r)) | (|(eind_r & een_r));
            assign fsrch_l[g] = ~unf & stat_r[`FS_ST_BASIC];
            assign csrch_l[g] = ~unf & mode1_r[`FS_M1_CAS_EN] & bsync &
                stat_r[`FS_ST_CAS];
            assign rsrch_l[g] = ~unf & mode1_r[`FS_M1_CRC_EN] & bsync &
                stat_r[`FS_ST_CRC] & ~iw_block;
            assign unf_l[g] = unf;
        end
    endgenerate

    // registered outputs
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rx_bit <= {LINKS{1'b0}};
            o_frame_search <= {LINKS{1'b0}};
            o_cas_search <= {LINKS{1'b0}};
            o_crc_search <= {LINKS{1'b0}};
            o_unframed <= {LINKS{1'b0}};
            o_int_b <= 1'b1;
        end else if (i_clk_en) begin
            // unframed links take the raw line bit
            o_rx_bit <= (unf_l & i_line_bit) | (~unf_l & i_proc_bit);
            o_frame_search <= fsrch_l;
            o_cas_search <= csrch_l;
            o_crc_search <= rsrch_l;
            o_unframed <= unf_l;
            o_int_b <= ~|irq_l;
        end
    end
endmodule // e1_rx_frame_sync_control
`default_nettype wire

// File: shared/e1_rx_frame_sync_defs.vh
// register indices, field positions, reset values and timing of the framer
`ifndef E1_RX_FRAME_SYNC_DEFS_VH
`define E1_RX_FRAME_SYNC_DEFS_VH
// register indices, byte address is four times the index
`define FS_IDX_MODE0 8'h4D
`define FS_IDX_MODE1 8'h4E
`define FS_IDX_STATUS 8'h4F
`define FS_IDX_SYNC_EN 8'h50
`define FS_IDX_EVENT_EN 8'h51
`define FS_IDX_SYNC_IND 8'h52
`define FS_IDX_EVENT_IND 8'h53
`define FS_LINK_STRIDE 12'h100
// framer_mode_primary fields
`define FS_M0_UNFRAMED 3
`define FS_M0_REF_CRC 2
`define FS_M0_AUTO 1
`define FS_M0_MANUAL 0
`define FS_MODE0_RST 4'h6
// framer_mode_criteria fields
`define FS_M1_LOSS_CRIT 7
`define FS_M1_CAS_EN 6
`define FS_M1_CRC_EN 5
`define FS_M1_CNT_NON_ALIGN_WORD 4
`define FS_M1_WORD_ERR 3
`define FS_M1_TS16_SPAN 2
`define FS_M1_ZERO_CHK 1
`define FS_M1_KEEP_SRCH 0
`define FS_MODE1_RST 8'hE0
// framer_sync_status fields
`define FS_ST_INTERWORK 4
`define FS_ST_CAS 3
`define FS_ST_CRC 2
`define FS_ST_OFFLINE 1
`define FS_ST_BASIC 0
`define FS_STATUS_RST 5'h0D
// sync indication: excess crc event above the five change flags
`define FS_SI_EXCESS 5
// loss criteria
`define FS_FAS_LOSS_CNT 2'h3
`define FS_CAS_LOSS_CNT 2'h2
// excessive crc-4 detection
`define FS_EXCESS_THRESH 10'h393
`define FS_WINDOW_S 1
`define FS_CLOCK_HZ 25000000
`endif

// File: src/e1_excess_crc_monitor.v
// excessive crc-4 error detector over a fixed window
`default_nettype none
module e1_excess_crc_monitor #(
    parameter WINDOW_CYCLES = 25000000,
    parameter [9:0] THRESH = 10'h393
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_clk_en,
    input wire i_in_sync,
    input wire i_crc_err,
    output reg o_excess
);
    reg [31:0] win_r;
    reg [9:0] cnt_r;
    wire win_end;
    assign win_end = (win_r == WINDOW_CYCLES - 1);
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            win_r <= 32'h0;
            cnt_r <= 10'h000;
            o_excess <= 1'b0;
        end else if (i_clk_en) begin
            o_excess <= 1'b0;
            if (!i_in_sync) begin
                // detection suspended while out of sync
                win_r <= 32'h0;
                cnt_r <= 10'h000;
            end else if (win_end) begin
                win_r <= 32'h0;
                cnt_r <= 10'h000;
                if (i_crc_err && cnt_r == THRESH - 10'h001) begin
                    o_excess <= 1'b1;
                end
            end else begin
                win_r <= win_r + 32'h1;
                if (i_crc_err && cnt_r != THRESH) begin
                    cnt_r <= cnt_r + 10'h001;
                    // one event per window on reaching the count
                    o_excess <= (cnt_r == THRESH - 10'h001);
                end
            end
        end
    end
endmodule // e1_excess_crc_monitor
`default_nettype wire

// File: verif/e1_line_rx_model.sv
// line receiver model: recovered bits, framer event pulses and levels
`default_nettype none
// codes: 0 line, 1 proc, 2 found, 3 fas chk, 4 fas bit, 5 fas pat,
// 6 non_align_word chk, 7 non_align_word err, 8 align, 9 offline, 10 cas found, 11 cas chk,
// 12 cas pat, 13 ts16, 14 cas start, 15 crc found, 16 crc start,
// 17 crc sub, 18 crc pat, 19 crc4, 20 interwork
module e1_line_rx_model (
    input wire logic i_clock,
    output logic [1:0] o_ev [0:20]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt = 3'h0;
    logic [1:0] lvl [0:20] = '{default: 2'h0};
    logic [1:0] pls [0:20] = '{default: 2'h0};
    always @(posedge i_clock) cnt <= cnt + 3'h1;
    always_comb begin
        for (int k = 0; k < 21; k++) o_ev[k] = lvl[k] | pls[k];
        // line bits change every cycle; proc bits change only every four (link 0) or two (link 1) cycles
        o_ev[0] = {cnt[0], ~cnt[0]};
        o_ev[1] = {cnt[1], cnt[2]};
    end
    // raise codes a and b on one link for n cycles
    task automatic pulse(input int a, input int b, input int ln, input int n);
        @(posedge i_clock);
        pls[a][ln] <= 1'b1;
        if (b != a) pls[b][ln] <= 1'b1;
        repeat (n) @(posedge i_clock);
        pls[a][ln] <= 1'b0;
        if (b != a) pls[b][ln] <= 1'b0;
    endtask
endmodule // e1_line_rx_model
`default_nettype wire

// File: verif/e1_rx_frame_sync_control_props.sv
// port assertions for the framer control block
`default_nettype none
module e1_rx_frame_sync_control_props #(parameter LINKS = 2) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [LINKS-1:0] i_line_bit,
    input wire logic [LINKS-1:0] i_proc_bit,
    input wire logic [LINKS-1:0] i_frame_found,
    input wire logic [LINKS-1:0] o_rx_bit,
    input wire logic [LINKS-1:0] o_frame_search,
    input wire logic [LINKS-1:0] o_cas_search,
    input wire logic [LINKS-1:0] o_crc_search,
    input wire logic [LINKS-1:0] o_unframed,
    input wire logic o_int_b
);
    logic wrote;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) wrote <= 1'b0;
        else if (i_psel && i_penable && i_pwrite && o_pready) wrote <= 1'b1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    AST_APB_ANSWER: assert property (i_clk_en && i_psel && i_penable
        && !o_pready |=> o_pready) else $error("pready late");
    AST_APB_PULSE: assert property (i_clk_en && o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    AST_ERR_QUAL: assert property (o_pslverr |-> o_pready && o_prdata == 0)
        else $error("pslverr without pready or with data");
    AST_BYPASS_BIT: assert property ($past(i_rst_b, 3) && o_unframed[0]
        && $past(o_unframed[0]) && $past(i_clk_en)
        |-> o_rx_bit[0] == $past(i_line_bit[0]))
        else $error("bypass bit wrong");
    AST_FRAMED_BIT: assert property ($past(i_rst_b, 3) && !o_unframed[0]
        && !$past(o_unframed[0]) && $past(i_clk_en)
        |-> o_rx_bit[0] == $past(i_proc_bit[0]))
        else $error("framed bit wrong");
    AST_FOUND_SYNC: assert property (i_frame_found[0] && !o_unframed[0]
        |-> ##[1:3] !o_frame_search[0]) else $error("no sync on found");
    AST_CAS_AFTER_SYNC: assert property ((o_cas_search & o_frame_search) == 0)
        else $error("cas search without basic sync");
    AST_CRC_AFTER_SYNC: assert property ((o_crc_search & o_frame_search) == 0)
        else $error("crc search without basic sync");
    AST_RESET_SEARCH: assert property (!$past(i_rst_b, 2) && $past(i_rst_b)
        |-> ##[0:2] o_frame_search == {LINKS{1'b1}}) else $error("no search");
    AST_INT_NEEDS_EN: assert property (!o_int_b |-> wrote)
        else $error("interrupt with reset enables");
endmodule // e1_rx_frame_sync_control_props
bind e1_rx_frame_sync_control e1_rx_frame_sync_control_props #(.LINKS(LINKS))
    u_props (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_line_bit(i_line_bit), .i_proc_bit(i_proc_bit),
    .i_frame_found(i_frame_found), .o_rx_bit(o_rx_bit),
    .o_frame_search(o_frame_search), .o_cas_search(o_cas_search),
    .o_crc_search(o_crc_search), .o_unframed(o_unframed), .o_int_b(o_int_b));
`default_nettype wire

// File: verif/e1_rx_frame_sync_control_tb_top.sv
// self-checking testbench for the framer control block
`default_nettype none
`include "e1_rx_frame_sync_defs.vh"
module e1_rx_frame_sync_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int m0 = `FS_IDX_MODE0;
    localparam int m1 = `FS_IDX_MODE1;
    localparam int st = `FS_IDX_STATUS;
    localparam int se = `FS_IDX_SYNC_EN;
    localparam int ee = `FS_IDX_EVENT_EN;
    localparam int si = `FS_IDX_SYNC_IND;
    localparam int ei = `FS_IDX_EVENT_IND;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, int_b;
    logic [1:0] ev [0:20];
    logic [1:0] rxb, fs, cs, rs, unf;
    int err_count = 0;
    int cmp_count = 0;
    always #20 i_clock = ~i_clock;
    e1_line_rx_model rx (.i_clock(i_clock), .o_ev(ev));
    e1_rx_frame_sync_control #(.LINKS(2), .WINDOW_CYCLES(60000)) uut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(1'b1),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_line_bit(ev[0]), .i_proc_bit(ev[1]),
        .i_frame_found(ev[2]), .i_fas_chk(ev[3]), .i_fas_bit_err(ev[4]),
        .i_fas_pat_err(ev[5]), .i_non_align_word_chk(ev[6]), .i_non_align_word_err(ev[7]),
        .i_align_moved(ev[8]), .i_offline_oos(ev[9]),
        .i_cas_mf_found(ev[10]), .i_cas_mf_chk(ev[11]),
        .i_cas_pat_err(ev[12]), .i_ts16_zero(ev[13]),
        .i_cas_mf_start(ev[14]), .i_crc_mf_found(ev[15]),
        .i_crc_mf_start(ev[16]), .i_crc_submf_start(ev[17]),
        .i_crc_pat_err(ev[18]), .i_crc4_err(ev[19]), .i_interwork(ev[20]),
        .o_rx_bit(rxb), .o_frame_search(fs), .o_cas_search(cs),
        .o_crc_search(rs), .o_unframed(unf), .o_int_b(int_b));
    task automatic test_done();
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic apb(input logic w, input int ln, input int idx,
        input logic [7:0] d, output logic [31:0] q, output logic e);
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        @(posedge i_clock);
        psel <= 1'b1;
        pwr <= w;
        paddr <= 12'(4 * (idx + ln * `FS_LINK_STRIDE));
        pwdata <= {24'h0, d};
        @(posedge i_clock);
        pen <= 1'b1;
        while (!r && n < 50) begin
            @(posedge i_clock);
            r = (pready === 1'b1);
            n++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (!r) err_count++;
    endtask
    task automatic wr(input int ln, input int idx, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, ln, idx, d, q, e);
        cyc(2);
    endtask
    task automatic rd(input int ln, input int idx, input logic [7:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, ln, idx, 8'h00, q, e);
        chk(q, {24'h0, x});
    endtask
    task automatic ev_n(input int a, input int b, input int n);
        repeat (n) rx.pulse(a, b, 0, 1);
        cyc(2);
    endtask
    task automatic t_reset();
        logic [7:0] rv [0:6] = '{8'h06, 8'hE0, 8'h0D, 0, 0, 0, 0};
        logic [31:0] q;
        logic e;
        for (int ln = 0; ln < 2; ln++)
            for (int k = 0; k < 7; k++) rd(ln, m0 + k, rv[k]);
        apb(1'b0, 0, 8'h60, 8'h00, q, e);
        chk({q[30:0], e}, 32'h1);
        wr(0, st, 8'hFF);
        rd(0, st, 8'h0D);
    endtask
    task automatic t_links();
        wr(1, m1, 8'h1F);
        rd(1, m1, 8'h1F);
        rd(0, m1, 8'hE0);
        wr(1, m1, 8'hE0);
    endtask
    task automatic t_sync();
        ev_n(2, 2, 1);
        rd(0, st, 8'h0C);
        rd(1, st, 8'h0D);
        chk(32'({cs[0], rs[0], fs[0]}), 32'h6);
        rd(0, si, 8'h01);
        wr(0, se, 8'h01);
        chk(32'(int_b), 32'h0);
        wr(0, si, 8'h00);
        rd(0, si, 8'h01);
        wr(0, si, 8'h01);
        chk(32'(int_b), 32'h1);
        wr(0, se, 8'h00);
        wr(0, m1, 8'hA0);
        chk(32'({cs[0], rs[0]}), 32'h1);
        wr(0, m1, 8'h80);
        chk(32'(rs[0]), 32'h0);
        wr(0, m1, 8'hE0);
        rx.lvl[20][0] <= 1'b1;
        cyc(3);
        rd(0, st, 8'h1C);
        rd(0, si, 8'h10);
        chk(32'(rs[0]), 32'h0);
        wr(0, m1, 8'hE1);
        chk(32'(rs[0]), 32'h1);
        rx.lvl[20][0] <= 1'b0;
        wr(0, m1, 8'hE0);
        wr(0, si, 8'hFF);
    endtask
    task automatic t_loss();
        ev_n(3, 5, 2);
        chk(32'(fs[0]), 32'h0);
        ev_n(3, 5, 1);
        chk(32'(fs[0]), 32'h1);
        ev_n(2, 2, 1);
        wr(0, m1, 8'h60);
        ev_n(6, 7, 3);
        chk(32'(fs[0]), 32'h0);
        wr(0, m1, 8'hE0);
        ev_n(6, 7, 3);
        chk(32'(fs[0]), 32'h1);
    endtask
    task automatic t_manual();
        ev_n(2, 2, 1);
        wr(0, m0, 8'h04);
        ev_n(3, 5, 3);
        chk(32'(fs[0]), 32'h0);
        wr(0, m0, 8'h05);
        chk(32'(fs[0]), 32'h1);
        ev_n(2, 2, 1);
        wr(0, m0, 8'h05);
        chk(32'(fs[0]), 32'h0);
        wr(0, m0, 8'h06);
    endtask
    task automatic t_event();
        wr(0, ee, 8'h03);
        wr(0, ei, 8'hFF);
        ev_n(6, 7, 1);
        rd(0, ei, 8'h00);
        wr(0, m1, 8'hF0);
        ev_n(6, 7, 1);
        ev_n(8, 8, 1);
        rd(0, ei, 8'h03);
        chk(32'(int_b), 32'h0);
        wr(0, ei, 8'hFF);
        chk(32'(int_b), 32'h1);
        wr(0, ee, 8'h00);
        wr(0, m1, 8'hE0);
    endtask
    task automatic t_unfr();
        wr(0, m0, 8'h0E);
        cyc(2);
        chk(32'({unf[0], fs[0]}), 32'h2);
        cyc(6);
        wr(0, m0, 8'h06);
    endtask
    task automatic t_excess();
        ev_n(2, 2, 1);
        ev_n(15, 15, 1);
        rd(0, st, 8'h08);
        ev_n(10, 10, 1);
        rd(0, st, 8'h00);
        ev_n(11, 12, 2);
        rd(0, st, 8'h08);
        wr(0, si, 8'hFF);
        rx.pulse(19, 19, 0, 914);
        cyc(2);
        rd(0, si, 8'h00);
        ev_n(19, 19, 1);
        rd(0, si, 8'h25);
        rd(0, st, 8'h0D);
    endtask
    initial begin
        cyc(4);
        i_rst_b <= 1'b1;
        t_reset();
        t_links();
        t_sync();
        t_loss();
        t_manual();
        t_event();
        t_unfr();
        t_excess();
        test_done();
    end
    initial begin
        #(2000000);
        err_count++;
        test_done();
    end
endmodule // e1_rx_frame_sync_control_tb_top
`default_nettype wire
